// >>> pmt8_pkg.sv
/*
 * Package for the 8-bit period match timer: register indices, field
 * positions, reset values and prescale codes.
 * Assumes a single 50 MHz system clock and a plain strobe register port.
 */
package pmt8_pkg;
    // ------------------------------------------------------------
    // register map (word indices on the plain port)
    // ------------------------------------------------------------
    localparam logic [2:0] PMT8_ADDR_CONTROL = 3'h0;
    localparam logic [2:0] PMT8_ADDR_COUNT   = 3'h1;
    localparam logic [2:0] PMT8_ADDR_PERIOD  = 3'h2;
    localparam logic [2:0] PMT8_ADDR_FLAG    = 3'h3;
    localparam logic [2:0] PMT8_ADDR_ENABLE  = 3'h4;
    localparam int         PMT8_ADDR_W       = 3;

    // ------------------------------------------------------------
    // control and flag fields
    // ------------------------------------------------------------
    localparam int PMT8_PRE_LSB  = 0;
    localparam int PMT8_PRE_MSB  = 1;
    localparam int PMT8_ON_BIT   = 2;
    localparam int PMT8_POST_LSB = 3;
    localparam int PMT8_POST_MSB = 6;
    localparam logic [7:0] PMT8_CONTROL_MASK = 8'h7F;
    localparam int PMT8_FLAG_BIT = 1;

    // ------------------------------------------------------------
    // reset values and divider terminal counts
    // ------------------------------------------------------------
    localparam logic [7:0] PMT8_CONTROL_RST = 8'h00;
    localparam logic [7:0] PMT8_COUNT_RST   = 8'h00;
    localparam logic [7:0] PMT8_PERIOD_RST  = 8'hFF;
    localparam int         PMT8_OSC_DIV     = 4;
    localparam logic [1:0] PMT8_FOSC_LAST   = 2'h3;
    localparam logic [3:0] PMT8_PRE1_LAST   = 4'h0;
    localparam logic [3:0] PMT8_PRE4_LAST   = 4'h3;
    localparam logic [3:0] PMT8_PRE16_LAST  = 4'hF;

    typedef enum logic [1:0] {
        PMT8_PRE_DIV1  = 2'b00,
        PMT8_PRE_DIV4  = 2'b01,
        PMT8_PRE_DIV16 = 2'b10
    } pmt8_pre_type;
endpackage : pmt8_pkg

// >>> pmt8_timer.sv
/*
 * 8-bit period match timer with prescaler, postscaler, sticky match flag,
 * enable mask and one level interrupt.
 * Assumes a master that issues one-cycle read or write strobes, never both.
 */
`timescale 1ns/1ns
module pmt8_timer (
    input  wire logic                        i_sys_clk,
    input  wire logic                        i_reset,
    input  wire logic [pmt8_pkg::PMT8_ADDR_W-1:0] i_addr,
    input  wire logic [7:0]                  i_wdata,
    input  wire logic                        i_wr,
    input  wire logic                        i_rd,
    output logic      [7:0]                  o_rdata,
    output logic                             o_irq,
    output logic                             o_match,
    output logic      [7:0]                  o_time_base
);
    import pmt8_pkg::*;

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [7:0] control_q;
    logic [7:0] count_q;
    logic [7:0] period_q;
    logic       flag_q;
    logic       enable_q;
    logic [1:0] fosc_q;
    logic [3:0] pre_q;
    logic [3:0] post_q;

    logic wr_control, wr_count, wr_period, wr_flag, wr_enable;
    logic inst_tick, pre_tick, match_tick, post_tick, timer_on;
    logic [3:0] pre_last;

    assign wr_control = i_wr && (i_addr == PMT8_ADDR_CONTROL);
    assign wr_count   = i_wr && (i_addr == PMT8_ADDR_COUNT);
    assign wr_period  = i_wr && (i_addr == PMT8_ADDR_PERIOD);
    assign wr_flag    = i_wr && (i_addr == PMT8_ADDR_FLAG);
    assign wr_enable  = i_wr && (i_addr == PMT8_ADDR_ENABLE);
    assign timer_on   = control_q[PMT8_ON_BIT];

    // decode of the prescale field; 1x patterns both mean 16
    function automatic logic [3:0] pre_decode(input logic [1:0] sel);
        logic [3:0] last;
        last = PMT8_PRE16_LAST;
        if (sel == PMT8_PRE_DIV1) begin
            last = PMT8_PRE1_LAST;
        end else if (sel == PMT8_PRE_DIV4) begin
            last = PMT8_PRE4_LAST;
        end
        return last;
    endfunction : pre_decode

    assign pre_last = pre_decode(control_q[PMT8_PRE_MSB:PMT8_PRE_LSB]);

    // ------------------------------------------------------------
    // divider chain
    // ------------------------------------------------------------
    // instruction clock is system clock divided by four; free running
    assign inst_tick  = (fosc_q == PMT8_FOSC_LAST);
    // a control write swallows the tick on its edge so the count holds
    assign pre_tick   = timer_on && inst_tick && (pre_q >= pre_last) &&
                        !wr_control;
    assign match_tick = pre_tick && (count_q == period_q);
    assign post_tick  = match_tick &&
                        (post_q >= control_q[PMT8_POST_MSB:PMT8_POST_LSB]);

    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            fosc_q <= 2'h0;
        end else begin
            fosc_q <= fosc_q + 2'h1;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_reset || wr_count || wr_control) begin
            pre_q <= 4'h0;
        end else if (timer_on && inst_tick) begin
            pre_q <= (pre_q >= pre_last) ? 4'h0 : pre_q + 4'h1;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_reset || wr_count || wr_control) begin
            post_q <= 4'h0;
        end else if (match_tick) begin
            post_q <= post_tick ? 4'h0 : post_q + 4'h1;
        end
    end

    // ------------------------------------------------------------
    // counter, period and control
    // ------------------------------------------------------------
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            count_q <= PMT8_COUNT_RST;
        end else if (wr_count) begin
            count_q <= i_wdata;
        end else if (match_tick) begin
            count_q <= 8'h00;
        end else if (pre_tick) begin
            count_q <= count_q + 8'h01;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            period_q <= PMT8_PERIOD_RST;
        end else if (wr_period) begin
            period_q <= i_wdata;
        end
    end

    // control write touches only control and dividers, never the count
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            control_q <= PMT8_CONTROL_RST;
        end else if (wr_control) begin
            control_q <= i_wdata & PMT8_CONTROL_MASK;
        end
    end

    // ------------------------------------------------------------
    // flag, enable, interrupt
    // ------------------------------------------------------------
    // set wins over a same-cycle write-one clear
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            flag_q <= 1'b0;
        end else if (post_tick) begin
            flag_q <= 1'b1;
        end else if (wr_flag && i_wdata[PMT8_FLAG_BIT]) begin
            flag_q <= 1'b0;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            enable_q <= 1'b0;
        end else if (wr_enable) begin
            enable_q <= i_wdata[PMT8_FLAG_BIT];
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= (flag_q || post_tick) && enable_q;
        end
    end

    // ------------------------------------------------------------
    // exported time base
    // ------------------------------------------------------------
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            o_match     <= 1'b0;
            o_time_base <= PMT8_COUNT_RST;
        end else begin
            o_match     <= match_tick;
            o_time_base <= count_q;
        end
    end

    // ------------------------------------------------------------
    // read port; unmapped reads give zero
    // ------------------------------------------------------------
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            o_rdata <= 8'h00;
        end else if (i_rd) begin
            unique case (i_addr)
                PMT8_ADDR_CONTROL: o_rdata <= control_q;
                PMT8_ADDR_COUNT:   o_rdata <= count_q;
                PMT8_ADDR_PERIOD:  o_rdata <= period_q;
                PMT8_ADDR_FLAG:    o_rdata <= {6'h00, flag_q, 1'b0};
                PMT8_ADDR_ENABLE:  o_rdata <= {6'h00, enable_q, 1'b0};
                default:           o_rdata <= 8'h00;
            endcase
        end else begin
            o_rdata <= 8'h00;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_match_seen;
        match_tick;
    endsequence

    property p_count_zero_after_match;
        @(posedge i_sys_clk) disable iff (i_reset)
        s_match_seen and !wr_count |=> count_q == 8'h00;
    endproperty
    a_count_zero_after_match: assert property (p_count_zero_after_match)
        else $error("count not cleared after match");

    property p_off_holds;
        @(posedge i_sys_clk) disable iff (i_reset)
        !timer_on && !wr_count |=> $stable(count_q);
    endproperty
    a_off_holds: assert property (p_off_holds)
        else $error("count moved while off");

    property p_ctrl_write_keeps_count;
        @(posedge i_sys_clk) disable iff (i_reset)
        wr_control |=> count_q == $past(count_q) && pre_q == 4'h0;
    endproperty
    a_ctrl_write_keeps_count: assert property (p_ctrl_write_keeps_count)
        else $error("control write changed count");

    property p_dividers_clear;
        @(posedge i_sys_clk) disable iff (i_reset)
        wr_count |=> pre_q == 4'h0 && post_q == 4'h0;
    endproperty
    a_dividers_clear: assert property (p_dividers_clear)
        else $error("dividers not cleared");

    property p_bit7_zero;
        @(posedge i_sys_clk) disable iff (i_reset)
        control_q[7] == 1'b0;
    endproperty
    a_bit7_zero: assert property (p_bit7_zero)
        else $error("control bit 7 set");

    property p_flag_sets;
        @(posedge i_sys_clk) disable iff (i_reset)
        post_tick |=> flag_q;
    endproperty
    a_flag_sets: assert property (p_flag_sets)
        else $error("flag not set on postscale");

    property p_post1;
        @(posedge i_sys_clk) disable iff (i_reset)
        match_tick && control_q[6:3] == 4'h0 |-> post_tick;
    endproperty
    a_post1: assert property (p_post1)
        else $error("1:1 postscale missed");

    property p_div1_rate;
        @(posedge i_sys_clk) disable iff (i_reset)
        pre_tick && control_q[1:0] == 2'b00 && !wr_control && !wr_count
        |-> ##4 pre_tick || !timer_on || $past(wr_control, 1)
            || $past(wr_control, 2) || $past(wr_control, 3)
            || wr_control;
    endproperty
    a_div1_rate: assert property (p_div1_rate)
        else $error("divide by one rate wrong");

    property p_match_out;
        @(posedge i_sys_clk) disable iff (i_reset)
        match_tick |=> o_match;
    endproperty
    a_match_out: assert property (p_match_out)
        else $error("match not exported");

    property p_irq;
        @(posedge i_sys_clk) disable iff (i_reset)
        flag_q && enable_q |=> o_irq;
    endproperty
    a_irq: assert property (p_irq)
        else $error("interrupt not raised");

    sequence s_flag_clear_req;
        wr_flag && i_wdata[PMT8_FLAG_BIT];
    endsequence

    property p_flag_clears;
        @(posedge i_sys_clk) disable iff (i_reset)
        s_flag_clear_req and !post_tick |=> !flag_q;
    endproperty
    a_flag_clears: assert property (p_flag_clears)
        else $error("flag not cleared by write of one");

    property p_flag_sticky;
        @(posedge i_sys_clk) disable iff (i_reset)
        flag_q && !wr_flag |=> flag_q;
    endproperty
    a_flag_sticky: assert property (p_flag_sticky)
        else $error("flag dropped without a clear");

    property p_time_base;
        @(posedge i_sys_clk) disable iff (i_reset)
        1'b1 |=> o_time_base == $past(count_q);
    endproperty
    a_time_base: assert property (p_time_base)
        else $error("time base does not follow count");

endmodule : pmt8_timer

// >>> pmt8_timer_test.sv
/*
 * Self-checking bench for the 8-bit period match timer: register table,
 * prescale and postscale ratios, sticky flag, mask and divider clearing.
 * Assumes the register indices and field layout of pmt8_pkg.
 */
`timescale 1ns/1ns
module pmt8_timer_test;
    import pmt8_pkg::*;

    typedef struct {
        logic       w;
        logic [2:0] a;
        logic [7:0] d;
        logic [7:0] e;
    } pmt8_row_type;

    localparam int CYC_LIMIT = 20000;

    logic                   sys_clk;
    logic                   reset;
    logic [PMT8_ADDR_W-1:0] addr;
    logic [7:0]             wdata;
    logic                   wr_en;
    logic                   rd_en;
    logic [7:0]             rdata;
    logic                   irq;
    logic                   match;
    logic [7:0]             time_base;
    int                     err_total;
    int                     checks_done;
    int                     cyc;
    logic [7:0]             d;
    int                     g;
    int                     n;
    int                     c;
    pmt8_row_type           rows [11];

    pmt8_timer dut (
        .i_sys_clk   (sys_clk),
        .i_reset     (reset),
        .i_addr      (addr),
        .i_wdata     (wdata),
        .i_wr        (wr_en),
        .i_rd        (rd_en),
        .o_rdata     (rdata),
        .o_irq       (irq),
        .o_match     (match),
        .o_time_base (time_base)
    );

    // ------------------------------------------------------------
    // clock, timeout and bus tasks
    // ------------------------------------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == CYC_LIMIT) begin
            err_total++;
            results();
        end
    end

    task automatic reg_write(input logic [2:0] a, input logic [7:0] v);
        @(posedge sys_clk);
        addr  <= a;
        wdata <= v;
        wr_en <= 1'b1;
        @(posedge sys_clk);
        wr_en <= 1'b0;
    endtask : reg_write

    // read data stands only in the cycle after the strobe
    task automatic reg_read(input logic [2:0] a, output logic [7:0] v);
        @(posedge sys_clk);
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge sys_clk);
        rd_en <= 1'b0;
        #1 v = rdata;
    endtask : reg_read

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t value %h expected %h", $time, got, exp);
        end
    endtask : chk8

    task automatic chk1(input logic got, input logic exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t irq %b expected %b", $time, got, exp);
        end
    endtask : chk1

    // first match after a control write is unaligned, so time the next one
    task automatic match_gap(output int gap);
        gap = 0;
        #1;
        while (match !== 1'b1 && gap < 2000) begin
            @(posedge sys_clk);
            #1 gap++;
        end
        gap = 1;
        @(posedge sys_clk);
        #1;
        while (match !== 1'b1 && gap < 2000) begin
            @(posedge sys_clk);
            #1 gap++;
        end
    endtask : match_gap

    task automatic results();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : results

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        reset = 1'b1;
        addr = '0;
        wdata = 8'h00;
        wr_en = 1'b0;
        rd_en = 1'b0;
        err_total = 0;
        checks_done = 0;
        cyc = 0;
        rows = '{
            '{1'b0, PMT8_ADDR_CONTROL, 8'h00, 8'h00},
            '{1'b0, PMT8_ADDR_COUNT,   8'h00, 8'h00},
            '{1'b0, PMT8_ADDR_PERIOD,  8'h00, 8'hFF},
            '{1'b0, PMT8_ADDR_FLAG,    8'h00, 8'h00},
            '{1'b0, PMT8_ADDR_ENABLE,  8'h00, 8'h00},
            '{1'b0, 3'h5,              8'h00, 8'h00},
            '{1'b1, PMT8_ADDR_PERIOD,  8'h5A, 8'h5A},
            '{1'b1, PMT8_ADDR_COUNT,   8'h33, 8'h33},
            '{1'b1, PMT8_ADDR_CONTROL, 8'hF8, 8'h78},
            '{1'b1, PMT8_ADDR_FLAG,    8'h02, 8'h00},
            '{1'b1, 3'h7,              8'h12, 8'h00}};
        repeat (8) @(posedge sys_clk);
        reset <= 1'b0;
        foreach (rows[i]) begin
            if (rows[i].w) reg_write(rows[i].a, rows[i].d);
            reg_read(rows[i].a, d);
            chk8(d, rows[i].e);
        end
        $display("done: register table");
        // period 1 gives a match every 2 ticks of 4 clocks times the divider
        reg_write(PMT8_ADDR_PERIOD, 8'h01);
        for (int k = 0; k < 4; k++) begin
            reg_write(PMT8_ADDR_CONTROL, 8'h04 | 8'(k));
            match_gap(g);
            chk8(8'(g), (k == 0) ? 8'h08 : (k == 1) ? 8'h20 : 8'h80);
        end
        $display("done: prescale ratios");
        reg_write(PMT8_ADDR_ENABLE, 8'h02);
        foreach (rows[i]) begin
            if (i > 2) break;
            reg_write(PMT8_ADDR_CONTROL, 8'h00);
            reg_write(PMT8_ADDR_FLAG, 8'h02);
            reg_write(PMT8_ADDR_CONTROL, {1'b0, 4'((i == 2) ? 15 : i), 3'h4});
            n = 0;
            c = 0;
            while (irq !== 1'b1 && c < 400) begin
                @(posedge sys_clk);
                #1 c++;
                if (match === 1'b1) n++;
            end
            chk8(8'(n), 8'((i == 2) ? 16 : i + 1));
        end
        reg_write(PMT8_ADDR_ENABLE, 8'h00);
        reg_read(PMT8_ADDR_FLAG, d);
        chk8(d, 8'h02);
        chk1(irq, 1'b0);
        reg_write(PMT8_ADDR_CONTROL, 8'h00);
        reg_write(PMT8_ADDR_FLAG, 8'h02);
        reg_read(PMT8_ADDR_FLAG, d);
        chk8(d, 8'h00);
        $display("done: postscale and flag");
        reg_write(PMT8_ADDR_COUNT, 8'h40);
        reg_write(PMT8_ADDR_CONTROL, 8'h78);
        repeat (20) @(posedge sys_clk);
        reg_read(PMT8_ADDR_COUNT, d);
        chk8(d, 8'h40);
        chk8(time_base, 8'h40);
        // a stale prescale count would step the counter within the 48-clock wait
        reg_write(PMT8_ADDR_PERIOD, 8'hFF);
        reg_write(PMT8_ADDR_CONTROL, 8'h06);
        repeat (37) @(posedge sys_clk);
        reg_write(PMT8_ADDR_COUNT, 8'h10);
        repeat (48) @(posedge sys_clk);
        reg_read(PMT8_ADDR_COUNT, d);
        chk8(d, 8'h10);
        repeat (30) @(posedge sys_clk);
        reg_read(PMT8_ADDR_COUNT, d);
        chk8(d, 8'h11);
        $display("done: stop and divider clear");
        @(posedge sys_clk);
        reset <= 1'b1;
        repeat (2) @(posedge sys_clk);
        reset <= 1'b0;
        reg_read(PMT8_ADDR_COUNT, d);
        chk8(d, 8'h00);
        reg_read(PMT8_ADDR_PERIOD, d);
        chk8(d, 8'hFF);
        reg_read(PMT8_ADDR_CONTROL, d);
        chk8(d, 8'h00);
        chk1(irq, 1'b0);
        $display("done: reset in mid-run");
        results();
    end
endmodule : pmt8_timer_test
